// *** hw/can_bit_timing_map.vh ***
// Purpose: register offsets, field positions and fixed timing counts for CAN bit timing
// Assumes: byte-wide registers on the device's internal register port
// Notes: definitions only
`ifndef CAN_BIT_TIMING_MAP_VH
`define CAN_BIT_TIMING_MAP_VH

////////////////////////////////////////////////////////////////////////////////
// register offsets
`define PHASE_TWO_CFG_ADDR 8'h28
`define SEGMENT_SAMPLING_CFG_ADDR 8'h29
`define PRESCALER_JUMP_WIDTH_CFG_ADDR 8'h2A

////////////////////////////////////////////////////////////////////////////////
// reset values
`define PRESCALER_JUMP_WIDTH_CFG_RST 8'h00
`define SEGMENT_SAMPLING_CFG_RST 8'h00
`define PHASE_TWO_CFG_RST 3'h0

////////////////////////////////////////////////////////////////////////////////
// prescaler_jump_width_cfg fields
`define QUANTUM_PRESCALER_MSB 5
`define QUANTUM_PRESCALER_LSB 0
`define RESYNC_JUMP_WIDTH_MSB 7
`define RESYNC_JUMP_WIDTH_LSB 6

// segment_sampling_cfg fields
`define PROPAGATION_LENGTH_MSB 2
`define PROPAGATION_LENGTH_LSB 0
`define PHASE_ONE_LENGTH_MSB 5
`define PHASE_ONE_LENGTH_LSB 3
`define TRIPLE_SAMPLING_BIT 6
`define PHASE_TWO_MODE_BIT 7

// phase_two_cfg field
`define PHASE_TWO_LENGTH_MSB 2
`define PHASE_TWO_LENGTH_LSB 0

////////////////////////////////////////////////////////////////////////////////
// timing counts, in time quanta
`define SYNC_SEGMENT_TQ 5'h01
`define PROCESSING_DELAY_TQ 5'h02

`endif

// *** hw/tq_prescaler.v ***
// Purpose: time quantum prescaler, half-quantum and quantum enables
// Assumes: i_ref_clk is the oscillator input
// Notes: one quantum is 2 x (prescaler + 1) clock periods
`timescale 1ns/100ps

module tq_prescaler (
	input wire i_ref_clk,
	input wire i_rst_n,
	input wire [5:0] i_prescaler,
	input wire i_restart,
	output wire o_half_tick,
	output wire o_tq_tick
);

reg [5:0] div_cnt_reg;
reg half_phase_reg;

////////////////////////////////////////////////////////////////////////////////
// each half quantum is prescaler + 1 clocks; two halves make one quantum
assign o_half_tick = (div_cnt_reg == i_prescaler);
assign o_tq_tick = o_half_tick && half_phase_reg;

always @(posedge i_ref_clk) begin
	if (!i_rst_n) begin
		div_cnt_reg <= 6'h00;
		half_phase_reg <= 1'b0;
	end else if (i_restart) begin
		div_cnt_reg <= 6'h00;
		half_phase_reg <= 1'b0;
	end else if (o_half_tick) begin
		div_cnt_reg <= 6'h00;
		half_phase_reg <= ~half_phase_reg;
	end else begin
		// guards a prescaler lowered below the running count
		div_cnt_reg <= (div_cnt_reg > i_prescaler) ? 6'h00 : div_cnt_reg + 6'h01;
	end
end

endmodule // tq_prescaler

// *** hw/can_bit_timing_config.v ***
// Purpose: CAN bit timing registers and the bit-time engine they steer
// Assumes: i_bus_receive_pin is asynchronous; recessive is 1
// Notes: mode, bus idle and transmit status come from neighbouring logic
//
// Contract
// - timing registers written only in configuration mode
// - quantum is 2 x (prescaler + 1) oscillator periods
// - jump width from bits 7-6 of first register
// - propagation segment is field plus one quanta
// - phase one is bits 5-3 plus one quanta
// - triple sampling: three samples, majority vote
// - single sample at end of phase one
// - mode one: phase two from third register field
// - mode zero: phase two is max(phase one, 2)
// - phase two field ignored when mode is zero
// - every bit starts with one-quantum sync segment
// - falling edge at bus idle restarts bit timing
`timescale 1ns/100ps
`include "can_bit_timing_map.vh"

module can_bit_timing_config (
	input wire i_ref_clk,
	input wire i_rst_n,
	input wire [7:0] i_reg_addr,
	input wire [7:0] i_reg_wdata,
	input wire i_reg_we,
	output reg [7:0] o_reg_rdata,
	input wire i_config_mode,
	input wire i_bus_idle,
	input wire i_transmitting,
	input wire i_bus_receive_pin,
	output wire o_tq_tick,
	output reg o_bit_start,
	output reg o_sample_point,
	output reg o_sampled_bit,
	output reg o_in_sync_segment
);

localparam ST_SYNC = 2'h0;
localparam ST_TSEG1 = 2'h1;
localparam ST_PS2 = 2'h2;

reg [7:0] prescaler_jump_width_cfg_reg;
reg [7:0] segment_sampling_cfg_reg;
reg [2:0] phase_two_cfg_reg;
reg [7:0] rdata_next;
reg rx_meta_reg;
reg rx_sync_reg;
reg rx_prev_reg;
reg [1:0] half_hist_reg;
reg [1:0] state_reg;
reg [4:0] seg_cnt_reg;
reg [2:0] extend_reg;
reg [2:0] shrink_reg;
reg synced_reg;
reg restart_pulse;
reg vote;

wire half_tick;
wire tq_tick;
wire [5:0] quantum_prescaler;
wire [4:0] jump_len;
wire [4:0] prop_len;
wire [4:0] ph1_len;
wire [4:0] ph2_prog_len;
wire [4:0] ph2_len;
wire [4:0] tseg1_len;
wire [4:0] tseg1_end;
wire [4:0] ph2_end;
wire [4:0] ph2_left;
wire [4:0] tseg1_err;
wire fall_edge;
wire hard_sync;
wire resync;

////////////////////////////////////////////////////////////////////////////////
// register port
always @(posedge i_ref_clk) begin
	if (!i_rst_n) begin
		prescaler_jump_width_cfg_reg <= `PRESCALER_JUMP_WIDTH_CFG_RST;
		segment_sampling_cfg_reg <= `SEGMENT_SAMPLING_CFG_RST;
		phase_two_cfg_reg <= `PHASE_TWO_CFG_RST;
	end else if (i_reg_we && i_config_mode) begin
		if (i_reg_addr == `PRESCALER_JUMP_WIDTH_CFG_ADDR)
			prescaler_jump_width_cfg_reg <= i_reg_wdata;
		if (i_reg_addr == `SEGMENT_SAMPLING_CFG_ADDR)
			segment_sampling_cfg_reg <= i_reg_wdata;
		if (i_reg_addr == `PHASE_TWO_CFG_ADDR)
			phase_two_cfg_reg <= i_reg_wdata[`PHASE_TWO_LENGTH_MSB:`PHASE_TWO_LENGTH_LSB];
	end
end

// unmapped addresses and unused bits of the third register read zero
always @* begin
	rdata_next = 8'h00;
	case (i_reg_addr)
	`PRESCALER_JUMP_WIDTH_CFG_ADDR: begin
		rdata_next = prescaler_jump_width_cfg_reg;
	end
	`SEGMENT_SAMPLING_CFG_ADDR: begin
		rdata_next = segment_sampling_cfg_reg;
	end
	`PHASE_TWO_CFG_ADDR: begin
		rdata_next = {5'h00, phase_two_cfg_reg};
	end
	default: begin
		rdata_next = 8'h00;
	end
	endcase
end

always @(posedge i_ref_clk) begin
	if (!i_rst_n)
		o_reg_rdata <= 8'h00;
	else
		o_reg_rdata <= rdata_next;
end

////////////////////////////////////////////////////////////////////////////////
// segment lengths in quanta
assign quantum_prescaler =
	prescaler_jump_width_cfg_reg[`QUANTUM_PRESCALER_MSB:`QUANTUM_PRESCALER_LSB];
assign jump_len = {3'h0, prescaler_jump_width_cfg_reg[`RESYNC_JUMP_WIDTH_MSB:
	`RESYNC_JUMP_WIDTH_LSB]} + 5'h01;
assign prop_len = {2'h0, segment_sampling_cfg_reg[`PROPAGATION_LENGTH_MSB:
	`PROPAGATION_LENGTH_LSB]} + 5'h01;
assign ph1_len = {2'h0, segment_sampling_cfg_reg[`PHASE_ONE_LENGTH_MSB:
	`PHASE_ONE_LENGTH_LSB]} + 5'h01;
assign ph2_prog_len = {2'h0, phase_two_cfg_reg} + 5'h01;
// field only reaches the mux on the programmed path
assign ph2_len = segment_sampling_cfg_reg[`PHASE_TWO_MODE_BIT] ? ph2_prog_len :
	((ph1_len > `PROCESSING_DELAY_TQ) ? ph1_len : `PROCESSING_DELAY_TQ);
assign tseg1_len = prop_len + ph1_len;
assign tseg1_end = tseg1_len + {2'h0, extend_reg} - 5'h01;
assign ph2_end = ph2_len - {2'h0, shrink_reg} - 5'h01;
assign ph2_left = ph2_len - seg_cnt_reg;
assign tseg1_err = seg_cnt_reg + 5'h01;

tq_prescaler u_tq_prescaler (
	.i_ref_clk(i_ref_clk),
	.i_rst_n(i_rst_n),
	.i_prescaler(quantum_prescaler),
	.i_restart(restart_pulse),
	.o_half_tick(half_tick),
	.o_tq_tick(tq_tick)
);

assign o_tq_tick = tq_tick;

////////////////////////////////////////////////////////////////////////////////
// receive pin synchroniser and edge detect
always @(posedge i_ref_clk) begin
	if (!i_rst_n) begin
		rx_meta_reg <= 1'b1;
		rx_sync_reg <= 1'b1;
		rx_prev_reg <= 1'b1;
	end else begin
		rx_meta_reg <= i_bus_receive_pin;
		rx_sync_reg <= rx_meta_reg;
		rx_prev_reg <= rx_sync_reg;
	end
end

// only recessive-to-dominant edges synchronise
assign fall_edge = rx_prev_reg && !rx_sync_reg;
assign hard_sync = fall_edge && i_bus_idle;
// one sync per bit, and only when the last sampled bit was recessive
assign resync = fall_edge && !i_bus_idle && !synced_reg && o_sampled_bit;

// half-quantum history feeds the vote
always @(posedge i_ref_clk) begin
	if (!i_rst_n)
		half_hist_reg <= 2'h3;
	else if (half_tick)
		half_hist_reg <= {half_hist_reg[0], rx_sync_reg};
end

always @* begin
	if (segment_sampling_cfg_reg[`TRIPLE_SAMPLING_BIT])
		vote = (half_hist_reg[1] & half_hist_reg[0]) | (half_hist_reg[1] & rx_sync_reg) |
			(half_hist_reg[0] & rx_sync_reg);
	else
		vote = rx_sync_reg;
end

////////////////////////////////////////////////////////////////////////////////
// bit-time engine
always @* begin
	restart_pulse = 1'b0;
	if (hard_sync)
		restart_pulse = 1'b1;
	else if (resync && state_reg == ST_PS2 && ph2_left <= jump_len)
		restart_pulse = 1'b1;
end

always @(posedge i_ref_clk) begin
	if (!i_rst_n) begin
		state_reg <= ST_SYNC;
		seg_cnt_reg <= 5'h00;
		extend_reg <= 3'h0;
		shrink_reg <= 3'h0;
		synced_reg <= 1'b0;
		o_bit_start <= 1'b0;
		o_sample_point <= 1'b0;
		o_sampled_bit <= 1'b1;
		o_in_sync_segment <= 1'b1;
	end else begin
		o_bit_start <= 1'b0;
		o_sample_point <= 1'b0;
		if (restart_pulse) begin
			// the edge now lies in a fresh sync segment
			state_reg <= ST_SYNC;
			seg_cnt_reg <= 5'h00;
			extend_reg <= 3'h0;
			shrink_reg <= 3'h0;
			synced_reg <= 1'b1;
			o_bit_start <= 1'b1;
			o_in_sync_segment <= 1'b1;
		end else begin
			if (resync) begin
				synced_reg <= 1'b1;
				// positive error lengthens phase one, not while transmitting
				if (state_reg == ST_TSEG1 && !i_transmitting)
					extend_reg <= (tseg1_err < jump_len) ? tseg1_err[2:0] : jump_len[2:0];
				else if (state_reg == ST_PS2)
					shrink_reg <= jump_len[2:0];
			end
			if (tq_tick) begin
				case (state_reg)
				ST_SYNC: begin
					// sync segment is one quantum long
					state_reg <= ST_TSEG1;
					seg_cnt_reg <= 5'h00;
					o_in_sync_segment <= 1'b0;
				end
				ST_TSEG1: begin
					if (seg_cnt_reg >= tseg1_end) begin
						state_reg <= ST_PS2;
						seg_cnt_reg <= 5'h00;
						o_sample_point <= 1'b1;
						o_sampled_bit <= vote;
					end else begin
						seg_cnt_reg <= seg_cnt_reg + 5'h01;
					end
				end
				ST_PS2: begin
					if (seg_cnt_reg >= ph2_end) begin
						state_reg <= ST_SYNC;
						seg_cnt_reg <= 5'h00;
						extend_reg <= 3'h0;
						shrink_reg <= 3'h0;
						synced_reg <= 1'b0;
						o_bit_start <= 1'b1;
						o_in_sync_segment <= 1'b1;
					end else begin
						seg_cnt_reg <= seg_cnt_reg + 5'h01;
					end
				end
				default: begin
					state_reg <= ST_SYNC;
					seg_cnt_reg <= 5'h00;
				end
				endcase
			end
		end
	end
end

endmodule // can_bit_timing_config

// *** bench/can_bus_node_model.sv ***
// Purpose: far CAN node that drives the receive line
// Assumes: bus is pulled up, recessive is high
// Notes: a released line goes back to recessive
`timescale 1ns/100ps
module can_bus_node_model (
	input wire i_drive_dominant,
	output wire o_bus_line
);
	// open drain bus modelled directly: dominant drives 0, a released line drives 1 for recessive
	assign o_bus_line = i_drive_dominant ? 1'b0 : 1'b1;
endmodule // can_bus_node_model

// *** bench/can_bit_timing_config_props.sv ***
// Purpose: port checker for the bit timing block
// Assumes: one clock domain
// Notes: bound to the top module
`timescale 1ns/100ps
`include "can_bit_timing_map.vh"
module can_bit_timing_config_props (
	input wire i_ref_clk,
	input wire i_rst_n,
	input wire [7:0] i_reg_addr,
	input wire [7:0] i_reg_wdata,
	input wire i_reg_we,
	input wire [7:0] o_reg_rdata,
	input wire i_config_mode,
	input wire i_bus_idle,
	input wire i_transmitting,
	input wire i_bus_receive_pin,
	input wire o_tq_tick,
	input wire o_bit_start,
	input wire o_sample_point,
	input wire o_sampled_bit,
	input wire o_in_sync_segment
);
	default clocking @(posedge i_ref_clk); endclocking
	default disable iff (!i_rst_n);
	sequence s_wr;
		i_reg_we && i_config_mode && (i_reg_addr == `PRESCALER_JUMP_WIDTH_CFG_ADDR
			|| i_reg_addr == `SEGMENT_SAMPLING_CFG_ADDR);
	endsequence
	property p_readback;
		s_wr ##1 $stable(i_reg_addr) |=> o_reg_rdata == $past(i_reg_wdata, 2);
	endproperty
	a_readback: assert property (p_readback) else $error("readback wrong");
	property p_hold;
		!(i_reg_we && i_config_mode) ##1 $stable(i_reg_addr) |=> $stable(o_reg_rdata);
	endproperty
	a_hold: assert property (p_hold) else $error("register moved");
	property p_hi_zero;
		$past(i_reg_addr) == `PHASE_TWO_CFG_ADDR |-> o_reg_rdata[7:3] == 5'h00;
	endproperty
	a_hi_zero: assert property (p_hi_zero) else $error("upper bits set");
	property p_unmapped;
		!($past(i_reg_addr) inside {`PHASE_TWO_CFG_ADDR, `SEGMENT_SAMPLING_CFG_ADDR,
			`PRESCALER_JUMP_WIDTH_CFG_ADDR}) |-> o_reg_rdata == 8'h00;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read");
	property p_bit_pulse;
		o_bit_start |=> !o_bit_start;
	endproperty
	a_bit_pulse: assert property (p_bit_pulse) else $error("bit start long");
	property p_start_sync;
		o_bit_start |-> o_in_sync_segment;
	endproperty
	a_start_sync: assert property (p_start_sync) else $error("no sync");
	// hard sync may restart the segment while idle
	property p_sync_len;
		o_in_sync_segment && o_tq_tick && !i_bus_idle |=> !o_in_sync_segment;
	endproperty
	a_sync_len: assert property (p_sync_len) else $error("sync too long");
	property p_sample_late;
		o_sample_point |-> !o_in_sync_segment;
	endproperty
	a_sample_late: assert property (p_sample_late) else $error("sample in sync");
endmodule // can_bit_timing_config_props
bind can_bit_timing_config can_bit_timing_config_props u_props (.*);

// *** bench/test_can_bit_timing_config.sv ***
// Purpose: register and bit timing bench
// Assumes: inputs change 1 ns after the rising edge
// Notes: small prescalers keep bits short
`timescale 1ns/100ps
`include "can_bit_timing_map.vh"
module test_can_bit_timing_config;
	reg clk = 1'b0, rst_n = 1'b0, we = 1'b0, cfg = 1'b1;
	reg idle = 1'b0, tx = 1'b0, dom = 1'b0;
	reg [7:0] addr = 8'h00, wdata = 8'h00, a1, a2, a3;
	reg [23:0] tab [0:3];
	wire rx, tick, bs, sp, sbit, insync;
	wire [7:0] rdata;
	integer n_fail = 0, n_checks = 0, n, q, ts, p2, k;
	always #50 clk = ~clk;
	can_bus_node_model node (.i_drive_dominant(dom), .o_bus_line(rx));
	can_bit_timing_config dut (.i_ref_clk(clk), .i_rst_n(rst_n), .i_reg_addr(addr),
		.i_reg_wdata(wdata), .i_reg_we(we), .o_reg_rdata(rdata), .i_config_mode(cfg),
		.i_bus_idle(idle), .i_transmitting(tx), .i_bus_receive_pin(rx), .o_tq_tick(tick),
		.o_bit_start(bs), .o_sample_point(sp), .o_sampled_bit(sbit),
		.o_in_sync_segment(insync));
	////////////////////////////////////////
	task close_out;
		begin
			$display("checks %0d mismatches %0d", n_checks, n_fail);
			if (n_fail == 0 && n_checks > 0)
				$display("Testbench passed");
			else
				$display("Testbench failed");
			$finish;
		end
	endtask
	task check(input string nm, input [31:0] seen, input [31:0] exp);
		begin
			n_checks = n_checks + 1;
			if (seen !== exp) begin
				n_fail = n_fail + 1;
				$display("BAD %s expected %0h seen %0h", nm, exp, seen);
			end
		end
	endtask
	task wr(input [7:0] a, input [7:0] d);
		begin
			@(posedge clk);
			#1 addr = a;
			wdata = d;
			we = 1'b1;
			@(posedge clk);
			#1 we = 1'b0;
		end
	endtask
	task rd(input [7:0] a, input [7:0] e, input string nm);
		begin
			@(posedge clk);
			#1 addr = a;
			repeat (2) @(posedge clk);
			#1 check(nm, rdata, e);
		end
	endtask
	// sel: 0 bit start, 1 sample point, 2 quantum tick; n counts edges
	task wt(input [1:0] sel);
		begin
			n = 0;
			do begin
				@(posedge clk);
				#1 n = n + 1;
			end while ((sel == 0 ? bs : sel == 1 ? sp : tick) !== 1'b1 && n < 3000);
			if (n == 3000) begin
				n_fail = n_fail + 1;
				close_out;
			end
		end
	endtask
	initial begin
		tab[0] = 24'h000007;
		tab[1] = 24'h412200;
		tab[2] = 24'h00D205;
		tab[3] = 24'h00BF01;
		repeat (5) @(posedge clk);
		#1 rst_n = 1'b1;
		rd(`PRESCALER_JUMP_WIDTH_CFG_ADDR, 8'h00, "cfg1 reset");
		rd(`SEGMENT_SAMPLING_CFG_ADDR, 8'h00, "cfg2 reset");
		rd(8'h30, 8'h00, "unmapped");
		for (k = 0; k < 4; k = k + 1) begin
			{a1, a2, a3} = tab[k];
			wr(`PRESCALER_JUMP_WIDTH_CFG_ADDR, a1);
			wr(`SEGMENT_SAMPLING_CFG_ADDR, a2);
			wr(`PHASE_TWO_CFG_ADDR, a3 | 8'hF8);
			rd(`PRESCALER_JUMP_WIDTH_CFG_ADDR, a1, "cfg1");
			rd(`SEGMENT_SAMPLING_CFG_ADDR, a2, "cfg2");
			rd(`PHASE_TWO_CFG_ADDR, a3, "cfg3");
			q = 2 * (a1[5:0] + 1);
			ts = a2[2:0] + a2[5:3] + 2;
			p2 = a2[7] ? a3[2:0] + 1 : (a2[5:3] > 0 ? a2[5:3] + 1 : 2);
			wt(2);
			wt(2);
			check("quantum", n, q);
			wt(0);
			wt(0);
			check("sync", insync, 1);
			wt(1);
			check("to sample", n, (1 + ts) * q);
			wt(0);
			check("phase two", n, p2 * q);
		end
		cfg = 1'b0;
		wr(`PRESCALER_JUMP_WIDTH_CFG_ADDR, 8'h3F);
		rd(`PRESCALER_JUMP_WIDTH_CFG_ADDR, a1, "locked");
		cfg = 1'b1;
		wr(`PRESCALER_JUMP_WIDTH_CFG_ADDR, 8'h07);
		// transmitting, so the early falling edge does not move the sample point
		tx = 1'b1;
		for (k = 0; k < 2; k = k + 1) begin
			wr(`SEGMENT_SAMPLING_CFG_ADDR, k ? 8'h40 : 8'h00);
			wt(0);
			wt(0);
			repeat (43) @(posedge clk);
			#1 dom = 1'b1;
			wt(1);
			@(posedge clk);
			#1 check("sampled", sbit, k);
			dom = 1'b0;
		end
		tx = 1'b0;
		idle = 1'b1;
		wt(0);
		repeat (20) @(posedge clk);
		#1 dom = 1'b1;
		wt(0);
		check("hard sync", n < 7, 1);
		wt(1);
		check("after sync", n, 48);
		dom = 1'b0;
		close_out;
	end
endmodule // test_can_bit_timing_config
